// ===== rtl/trlsr_pkg.sv
// register map, reset values and status layout for the result/limit/status bank
package trlsr_pkg;
  localparam logic [7:0]  PTR_LOCAL_HIGH       = 8'h00;
  localparam logic [7:0]  PTR_REMOTE_HIGH      = 8'h01;
  localparam logic [7:0]  PTR_STATUS           = 8'h02;
  localparam logic [7:0]  RD_LOCAL_UPPER       = 8'h05;
  localparam logic [7:0]  RD_LOCAL_LOWER       = 8'h06;
  localparam logic [7:0]  RD_REMOTE_UPPER      = 8'h07;
  localparam logic [7:0]  RD_REMOTE_LOWER      = 8'h08;
  localparam logic [7:0]  WR_LOCAL_UPPER       = 8'h0b;
  localparam logic [7:0]  WR_LOCAL_LOWER       = 8'h0c;
  localparam logic [7:0]  WR_REMOTE_UPPER      = 8'h0d;
  localparam logic [7:0]  WR_REMOTE_LOWER      = 8'h0e;
  localparam logic [7:0]  PTR_REMOTE_LOW       = 8'h10;
  localparam logic [7:0]  PTR_REMOTE_UPPER_LOW = 8'h13;
  localparam logic [7:0]  PTR_REMOTE_LOWER_LOW = 8'h14;
  localparam logic [7:0]  PTR_LOCAL_LOW        = 8'h15;
  localparam logic [7:0]  PTR_LOCAL_UPPER_LOW  = 8'h16;
  localparam logic [7:0]  PTR_LOCAL_LOWER_LOW  = 8'h17;
  localparam logic [7:0]  PTR_REMOTE_CRIT      = 8'h19;
  localparam logic [7:0]  PTR_LOCAL_CRIT       = 8'h20;
  localparam logic [7:0]  PTR_HYST             = 8'h21;
  localparam logic [7:0]  POINTER_RESET        = 8'h00;

  localparam logic [11:0] RESULT_RESET         = 12'h000;
  localparam logic [11:0] UPPER_RESET          = 12'h550;
  localparam logic [11:0] LOWER_RESET          = 12'h000;
  localparam logic [7:0]  CRIT_RESET           = 8'h55;
  localparam logic [7:0]  HYST_RESET           = 8'h0a;
  localparam logic [3:0]  FRAC_ZERO            = 4'h0;

  localparam int          ST_BUSY              = 7;
  localparam int          ST_LOCAL_OVER        = 6;
  localparam int          ST_LOCAL_UNDER       = 5;
  localparam int          ST_REMOTE_OVER       = 4;
  localparam int          ST_REMOTE_UNDER      = 3;
  localparam int          ST_OPEN              = 2;
  localparam int          ST_REMOTE_CRIT       = 1;
  localparam int          ST_LOCAL_CRIT        = 0;

  // latched flag vector positions
  localparam int          LF_LOCAL_OVER        = 0;
  localparam int          LF_LOCAL_UNDER       = 1;
  localparam int          LF_REMOTE_OVER       = 2;
  localparam int          LF_REMOTE_UNDER      = 3;
  localparam int          LF_OPEN              = 4;

  typedef enum logic [1:0] {COH_NONE, COH_LOCAL, COH_REMOTE} trlsr_coh_t;
endpackage

// ===== rtl/trlsr_hyst_cmp.sv
// threshold comparator with hysteresis, updated at the end of a conversion
`timescale 1ns/100ps
module trlsr_hyst_cmp
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        update,
  input  wire logic [11:0] value,
  input  wire logic [11:0] limit,
  input  wire logic [11:0] hyst,
  output logic             active
);
  logic [11:0] floorLevel;

  // saturate so a small limit with big hysteresis cannot wrap
  always_comb
  begin
    floorLevel = (hyst > limit) ? 12'h000 : limit - hyst;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      active <= 1'b0;
    else if (update && (value > limit))
      active <= 1'b1;
    else if (update && (value <= floorLevel))
      active <= 1'b0;
  end
endmodule

// ===== rtl/trlsr_regs.sv
// result, limit, critical limit, hysteresis and status register bank
`timescale 1ns/100ps
module trlsr_regs
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        cmdStart,
  input  wire logic [7:0]  cmdPointer,
  input  wire logic        wrByte,
  input  wire logic        wrSecond,
  input  wire logic [7:0]  wrData,
  input  wire logic        rdByte,
  input  wire logic        rdSecond,
  output logic      [7:0]  rdData,
  output logic             rdValid,
  input  wire logic        convBusy,
  input  wire logic        convDone,
  input  wire logic        convRemote,
  input  wire logic        convOpen,
  input  wire logic [11:0] convResult,
  input  wire logic        pinFunctionSelect,
  input  wire logic        alertRespond,
  output logic             alertOut,
  output logic             alertOe_b
);
  logic [7:0]         pointer;
  logic [7:0]         effWrAddr;
  logic [7:0]         effRdAddr;
  logic [7:0]         rdMux;
  logic [11:0]        localResult;
  logic [11:0]        remoteResult;
  logic [11:0]        localUpper;
  logic [11:0]        localLower;
  logic [11:0]        remoteUpper;
  logic [11:0]        remoteLower;
  logic [7:0]         localCrit;
  logic [7:0]         remoteCrit;
  logic [7:0]         hysteresis;
  logic [3:0]         shadowLow;
  trlsr_pkg::trlsr_coh_t coh;
  logic               localDone;
  logic               remoteDone;
  logic               remoteGood;
  logic               statusRead;
  logic [4:0]         latchSet;
  logic [4:0]         latchCond;
  logic [4:0]         latched;
  logic [4:0]         latchedPrev;
  logic               localCritFlag;
  logic               remoteCritFlag;
  logic               localOverHyst;
  logic               remoteOverHyst;
  logic [7:0]         statusVec;
  logic               alertLatch;
  logic               next_alertOe_b;

  assign localDone  = convDone & ~convRemote;
  assign remoteDone = convDone & convRemote;
  assign remoteGood = remoteDone & ~convOpen;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      pointer <= trlsr_pkg::POINTER_RESET;
    else if (cmdStart)
      pointer <= cmdPointer;
  end

  // second byte of a two-byte access lands on the paired low byte
  always_comb
  begin
    effWrAddr = pointer;
    if (wrSecond)
    begin
      case (pointer)
        trlsr_pkg::WR_LOCAL_UPPER:  effWrAddr = trlsr_pkg::PTR_LOCAL_UPPER_LOW;
        trlsr_pkg::WR_LOCAL_LOWER:  effWrAddr = trlsr_pkg::PTR_LOCAL_LOWER_LOW;
        trlsr_pkg::WR_REMOTE_UPPER: effWrAddr = trlsr_pkg::PTR_REMOTE_UPPER_LOW;
        trlsr_pkg::WR_REMOTE_LOWER: effWrAddr = trlsr_pkg::PTR_REMOTE_LOWER_LOW;
        default:                    effWrAddr = pointer;
      endcase
    end
  end

  always_comb
  begin
    effRdAddr = pointer;
    if (rdSecond)
    begin
      case (pointer)
        trlsr_pkg::PTR_LOCAL_HIGH:  effRdAddr = trlsr_pkg::PTR_LOCAL_LOW;
        trlsr_pkg::PTR_REMOTE_HIGH: effRdAddr = trlsr_pkg::PTR_REMOTE_LOW;
        trlsr_pkg::RD_LOCAL_UPPER:  effRdAddr = trlsr_pkg::PTR_LOCAL_UPPER_LOW;
        trlsr_pkg::RD_LOCAL_LOWER:  effRdAddr = trlsr_pkg::PTR_LOCAL_LOWER_LOW;
        trlsr_pkg::RD_REMOTE_UPPER: effRdAddr = trlsr_pkg::PTR_REMOTE_UPPER_LOW;
        trlsr_pkg::RD_REMOTE_LOWER: effRdAddr = trlsr_pkg::PTR_REMOTE_LOWER_LOW;
        default:                    effRdAddr = pointer;
      endcase
    end
  end

  // results only change from the converter side
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      localResult <= trlsr_pkg::RESULT_RESET;
    else if (localDone)
      localResult <= convResult;
  end

  // an open diode gives no valid reading, so the old result stays
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      remoteResult <= trlsr_pkg::RESULT_RESET;
    else if (remoteGood)
      remoteResult <= convResult;
  end

  // limits are stored raw; no reformatting on range change
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      localUpper  <= trlsr_pkg::UPPER_RESET;
      localLower  <= trlsr_pkg::LOWER_RESET;
      remoteUpper <= trlsr_pkg::UPPER_RESET;
      remoteLower <= trlsr_pkg::LOWER_RESET;
      localCrit   <= trlsr_pkg::CRIT_RESET;
      remoteCrit  <= trlsr_pkg::CRIT_RESET;
      hysteresis  <= trlsr_pkg::HYST_RESET;
    end
    else if (wrByte)
    begin
      // result and status addresses fall to default
      case (effWrAddr)
        trlsr_pkg::WR_LOCAL_UPPER:       localUpper[11:4]  <= wrData;
        trlsr_pkg::PTR_LOCAL_UPPER_LOW:  localUpper[3:0]   <= wrData[7:4];
        trlsr_pkg::WR_LOCAL_LOWER:       localLower[11:4]  <= wrData;
        trlsr_pkg::PTR_LOCAL_LOWER_LOW:  localLower[3:0]   <= wrData[7:4];
        trlsr_pkg::WR_REMOTE_UPPER:      remoteUpper[11:4] <= wrData;
        trlsr_pkg::PTR_REMOTE_UPPER_LOW: remoteUpper[3:0]  <= wrData[7:4];
        trlsr_pkg::WR_REMOTE_LOWER:      remoteLower[11:4] <= wrData;
        trlsr_pkg::PTR_REMOTE_LOWER_LOW: remoteLower[3:0]  <= wrData[7:4];
        trlsr_pkg::PTR_LOCAL_CRIT:       localCrit         <= wrData;
        trlsr_pkg::PTR_REMOTE_CRIT:      remoteCrit        <= wrData;
        trlsr_pkg::PTR_HYST:             hysteresis        <= wrData;
        default:                         ;
      endcase
    end
  end

  // high byte read freezes the matching low nibble until the next read
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      coh       <= trlsr_pkg::COH_NONE;
      shadowLow <= 4'h0;
    end
    else if (rdByte)
    begin
      if (effRdAddr == trlsr_pkg::PTR_LOCAL_HIGH)
      begin
        coh       <= trlsr_pkg::COH_LOCAL;
        shadowLow <= localResult[3:0];
      end
      else if (effRdAddr == trlsr_pkg::PTR_REMOTE_HIGH)
      begin
        coh       <= trlsr_pkg::COH_REMOTE;
        shadowLow <= remoteResult[3:0];
      end
      else
        coh <= trlsr_pkg::COH_NONE;
    end
  end

  trlsr_hyst_cmp localCritCmp
  (
    .clock  (clock),
    .rst_b  (rst_b),
    .update (localDone),
    .value  ({convResult[11:4], trlsr_pkg::FRAC_ZERO}),
    .limit  ({localCrit, trlsr_pkg::FRAC_ZERO}),
    .hyst   ({hysteresis, trlsr_pkg::FRAC_ZERO}),
    .active (localCritFlag)
  );

  trlsr_hyst_cmp remoteCritCmp
  (
    .clock  (clock),
    .rst_b  (rst_b),
    .update (remoteGood),
    .value  ({convResult[11:4], trlsr_pkg::FRAC_ZERO}),
    .limit  ({remoteCrit, trlsr_pkg::FRAC_ZERO}),
    .hyst   ({hysteresis, trlsr_pkg::FRAC_ZERO}),
    .active (remoteCritFlag)
  );

  trlsr_hyst_cmp localOverCmp
  (
    .clock  (clock),
    .rst_b  (rst_b),
    .update (localDone),
    .value  (convResult),
    .limit  (localUpper),
    .hyst   ({hysteresis, trlsr_pkg::FRAC_ZERO}),
    .active (localOverHyst)
  );

  trlsr_hyst_cmp remoteOverCmp
  (
    .clock  (clock),
    .rst_b  (rst_b),
    .update (remoteGood),
    .value  (convResult),
    .limit  (remoteUpper),
    .hyst   ({hysteresis, trlsr_pkg::FRAC_ZERO}),
    .active (remoteOverHyst)
  );

  always_comb
  begin
    latchSet                            = '0;
    latchSet[trlsr_pkg::LF_LOCAL_OVER]   = localDone && (convResult > localUpper);
    latchSet[trlsr_pkg::LF_LOCAL_UNDER]  = localDone && (convResult < localLower);
    latchSet[trlsr_pkg::LF_REMOTE_OVER]  = remoteGood && (convResult > remoteUpper);
    latchSet[trlsr_pkg::LF_REMOTE_UNDER] = remoteGood && (convResult < remoteLower);
    latchSet[trlsr_pkg::LF_OPEN]         = remoteDone && convOpen;
  end

  // last conversion's verdict per flag; a read may only clear a flag whose cause is gone
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      latchCond <= '0;
    else
    begin
      if (localDone)
      begin
        latchCond[trlsr_pkg::LF_LOCAL_OVER]  <= latchSet[trlsr_pkg::LF_LOCAL_OVER];
        latchCond[trlsr_pkg::LF_LOCAL_UNDER] <= latchSet[trlsr_pkg::LF_LOCAL_UNDER];
      end
      if (remoteDone)
        latchCond[trlsr_pkg::LF_OPEN] <= convOpen;
      if (remoteGood)
      begin
        latchCond[trlsr_pkg::LF_REMOTE_OVER]  <= latchSet[trlsr_pkg::LF_REMOTE_OVER];
        latchCond[trlsr_pkg::LF_REMOTE_UNDER] <= latchSet[trlsr_pkg::LF_REMOTE_UNDER];
      end
    end
  end

  assign statusRead = rdByte && (effRdAddr == trlsr_pkg::PTR_STATUS);

  // set beats a clearing read in the same cycle
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      latched <= '0;
    else
    begin
      for (int i = 0; i < 5; i++)
      begin
        if (latchSet[i])
          latched[i] <= 1'b1;
        else if (statusRead && !latchCond[i])
          latched[i] <= 1'b0;
      end
    end
  end

  always_comb
  begin
    statusVec                            = '0;
    statusVec[trlsr_pkg::ST_BUSY]         = convBusy;
    statusVec[trlsr_pkg::ST_LOCAL_OVER]   = pinFunctionSelect ? localOverHyst
                                                              : latched[trlsr_pkg::LF_LOCAL_OVER];
    statusVec[trlsr_pkg::ST_LOCAL_UNDER]  = latched[trlsr_pkg::LF_LOCAL_UNDER];
    statusVec[trlsr_pkg::ST_REMOTE_OVER]  = pinFunctionSelect ? remoteOverHyst
                                                              : latched[trlsr_pkg::LF_REMOTE_OVER];
    statusVec[trlsr_pkg::ST_REMOTE_UNDER] = latched[trlsr_pkg::LF_REMOTE_UNDER];
    statusVec[trlsr_pkg::ST_OPEN]         = latched[trlsr_pkg::LF_OPEN];
    statusVec[trlsr_pkg::ST_REMOTE_CRIT]  = remoteCritFlag;
    statusVec[trlsr_pkg::ST_LOCAL_CRIT]   = localCritFlag;
  end

  // unmapped addresses and unused low-byte nibbles read as zero
  always_comb
  begin
    rdMux = 8'h00;
    case (effRdAddr)
      trlsr_pkg::PTR_LOCAL_HIGH:       rdMux = localResult[11:4];
      trlsr_pkg::PTR_REMOTE_HIGH:      rdMux = remoteResult[11:4];
      trlsr_pkg::PTR_LOCAL_LOW:        rdMux = {(coh == trlsr_pkg::COH_LOCAL) ? shadowLow
                                                : localResult[3:0], trlsr_pkg::FRAC_ZERO};
      trlsr_pkg::PTR_REMOTE_LOW:       rdMux = {(coh == trlsr_pkg::COH_REMOTE) ? shadowLow
                                                : remoteResult[3:0], trlsr_pkg::FRAC_ZERO};
      trlsr_pkg::PTR_STATUS:           rdMux = statusVec;
      trlsr_pkg::RD_LOCAL_UPPER:       rdMux = localUpper[11:4];
      trlsr_pkg::PTR_LOCAL_UPPER_LOW:  rdMux = {localUpper[3:0], trlsr_pkg::FRAC_ZERO};
      trlsr_pkg::RD_LOCAL_LOWER:       rdMux = localLower[11:4];
      trlsr_pkg::PTR_LOCAL_LOWER_LOW:  rdMux = {localLower[3:0], trlsr_pkg::FRAC_ZERO};
      trlsr_pkg::RD_REMOTE_UPPER:      rdMux = remoteUpper[11:4];
      trlsr_pkg::PTR_REMOTE_UPPER_LOW: rdMux = {remoteUpper[3:0], trlsr_pkg::FRAC_ZERO};
      trlsr_pkg::RD_REMOTE_LOWER:      rdMux = remoteLower[11:4];
      trlsr_pkg::PTR_REMOTE_LOWER_LOW: rdMux = {remoteLower[3:0], trlsr_pkg::FRAC_ZERO};
      trlsr_pkg::PTR_LOCAL_CRIT:       rdMux = localCrit;
      trlsr_pkg::PTR_REMOTE_CRIT:      rdMux = remoteCrit;
      trlsr_pkg::PTR_HYST:             rdMux = hysteresis;
      default:                         rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      rdData  <= 8'h00;
      rdValid <= 1'b0;
    end
    else
    begin
      rdValid <= rdByte;
      if (rdByte)
        rdData <= rdMux;
    end
  end

  // pin stays pulled until alert response, not until status read
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      latchedPrev <= '0;
      alertLatch  <= 1'b0;
    end
    else
    begin
      latchedPrev <= latched;
      if (!pinFunctionSelect && |(latched & ~latchedPrev))
        alertLatch <= 1'b1;
      else if (alertRespond)
        alertLatch <= 1'b0;
    end
  end

  always_comb
  begin
    if (pinFunctionSelect)
      next_alertOe_b = ~(localOverHyst | remoteOverHyst);
    else
      next_alertOe_b = ~alertLatch;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      alertOe_b <= 1'b1;
    else
      alertOe_b <= next_alertOe_b;
  end

  assign alertOut = 1'b0;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_result_update: assert property (
    localDone |=> localResult == $past(convResult))
    else $error("local result not refreshed");
  a_ro_write: assert property (
    wrByte && !convDone && (effWrAddr == trlsr_pkg::PTR_LOCAL_HIGH)
    |=> $stable(localResult) && $stable(remoteResult))
    else $error("read-only result changed by write");
  a_pair_coherent: assert property (
    rdByte && !rdSecond && (pointer == trlsr_pkg::PTR_LOCAL_HIGH) ##1
    rdByte && rdSecond && (pointer == trlsr_pkg::PTR_LOCAL_HIGH)
    |=> rdData == {$past(localResult[3:0], 2), trlsr_pkg::FRAC_ZERO})
    else $error("two-byte read mixed conversions");
  a_coh_lapse: assert property (
    rdByte && (effRdAddr == trlsr_pkg::PTR_LOCAL_LOW) && (coh != trlsr_pkg::COH_LOCAL)
    |=> rdData == {$past(localResult[3:0]), trlsr_pkg::FRAC_ZERO})
    else $error("lapsed low byte not live");
  a_busy_live: assert property (
    statusRead |=> rdData[trlsr_pkg::ST_BUSY] == $past(convBusy))
    else $error("busy bit wrong");
  a_pointer_load: assert property (
    cmdStart |=> pointer == $past(cmdPointer))
    else $error("pointer not loaded");
  a_flag_hold: assert property (
    statusRead |=> (latched | ~$past(latchCond) | ~$past(latched)) == 5'h1f)
    else $error("flag cleared while cause stands");
  a_alert_sticky: assert property (
    alertLatch && !alertRespond && !pinFunctionSelect ##1 !pinFunctionSelect |=> !alertOe_b)
    else $error("alert released without response");
  a_limit_write: assert property (
    wrByte && !wrSecond && (pointer == trlsr_pkg::WR_LOCAL_UPPER)
    |=> localUpper[11:4] == $past(wrData))
    else $error("local high limit not written");
  a_crit_set: assert property (
    localDone && (convResult[11:4] > localCrit) |=> localCritFlag)
    else $error("critical flag not set");

  c_status_clear: cover property (statusRead && |latched ##1 latched == '0);
  c_pair_read: cover property (rdByte && !rdSecond && (pointer == trlsr_pkg::PTR_REMOTE_HIGH) ##1 rdByte && rdSecond);
  c_alert_cycle: cover property (!alertOe_b && alertRespond ##[1:4] alertOe_b);
endmodule

// ===== verification/trlsr_conv_model.sv
// converter stand-in: busy for a fixed span, then a one-cycle done pulse
`timescale 1ns/100ps
module trlsr_conv_model
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic        remote,
  input  wire logic        open,
  input  wire logic [11:0] value,
  output logic             convBusy,
  output logic             convDone,
  output logic             convRemote,
  output logic             convOpen,
  output logic      [11:0] convResult
);
  logic [3:0] count;
  // qualifiers are only valid with done; inverted otherwise so stale data never matches
  assign convResult = convDone ? value : ~value;
  assign convRemote = convDone ? remote : ~remote;
  assign convOpen   = convDone ? open : ~open;
  always_ff @(posedge clock)
  begin
    convDone <= 1'b0;
    if (!rst_b)
    begin
      convBusy <= 1'b0;
      count    <= 4'h0;
    end
    else if (start && !convBusy)
    begin
      convBusy <= 1'b1;
      count    <= 4'h8;
    end
    else if (convBusy)
    begin
      count    <= count - 4'h1;
      convBusy <= (count != 4'h1);
      convDone <= (count == 4'h1);
    end
  end
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the result, limit and status bank
`timescale 1ns/100ps
module tb_top;
  logic        clock, rst_b, cmdStart, wrByte, wrSecond, rdByte, rdSecond, rdValid;
  logic        convBusy, convDone, convRemote, convOpen, pinFunctionSelect, alertRespond;
  logic        alertOut, alertOe_b, convStart, remoteIn, openIn;
  logic [7:0]  cmdPointer, wrData, rdData;
  logic [11:0] convResult, convValue;
  int          err_count, samples_checked;
  logic [15:0] rows [17] = '{16'h0555, 16'h0600, 16'h0755, 16'h0800, 16'h1955, 16'h2055, 16'h210a,
    16'h0000, 16'h0100, 16'h1000, 16'h1500, 16'h1300, 16'h1400, 16'h1600, 16'h1700, 16'h0200, 16'h3000};
  // write pointer, read pointer, low-byte pointer, high byte
  logic [31:0] lims [4] = '{32'h0b051640, 32'h0c061710, 32'h0d071340, 32'h0e081410};

  trlsr_regs dut_u (.clock, .rst_b, .cmdStart, .cmdPointer, .wrByte, .wrSecond, .wrData, .rdByte,
    .rdSecond, .rdData, .rdValid, .convBusy, .convDone, .convRemote, .convOpen, .convResult,
    .pinFunctionSelect, .alertRespond, .alertOut, .alertOe_b);
  trlsr_conv_model conv_u (.clock, .rst_b, .start(convStart), .remote(remoteIn), .open(openIn),
    .value(convValue), .convBusy, .convDone, .convRemote, .convOpen, .convResult);

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // every task except check and stop_test starts and ends on an edge; the idle edge keeps strobes from being set twice at once
  task automatic cmd(input logic [7:0] p);
    cmdStart   <= 1'b1;
    cmdPointer <= p;
    @(posedge clock);
    cmdStart <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] d, input logic s);
    wrByte   <= 1'b1;
    wrSecond <= s;
    wrData   <= d;
    @(posedge clock);
    wrByte <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic s, input logic [7:0] exp);
    rdByte   <= 1'b1;
    rdSecond <= s;
    @(posedge clock);
    rdByte <= 1'b0;
    #1;
    check(rdValid === 1'b1 ? rdData : ~exp, exp);
    @(posedge clock);
  endtask

  // pin register trails the flags by one more edge
  task automatic pin(input logic exp);
    @(posedge clock);
    #1;
    check({6'h00, alertOut, alertOe_b}, {6'h00, 1'b0, exp});
    @(posedge clock);
  endtask

  // back-to-back two-byte read, second byte on the very next edge
  task automatic rd2(input logic [7:0] hi, input logic [7:0] lo);
    rdByte   <= 1'b1;
    rdSecond <= 1'b0;
    @(posedge clock);
    rdSecond <= 1'b1;
    #1;
    check(rdValid === 1'b1 ? rdData : ~hi, hi);
    @(posedge clock);
    rdByte <= 1'b0;
    #1;
    check(rdValid === 1'b1 ? rdData : ~lo, lo);
    @(posedge clock);
  endtask

  task automatic respond();
    alertRespond <= 1'b1;
    @(posedge clock);
    alertRespond <= 1'b0;
    @(posedge clock);
  endtask

  task automatic conv(input logic r, input logic o, input logic [11:0] v, input logic peek);
    int n;
    convStart <= 1'b1;
    remoteIn  <= r;
    openIn    <= o;
    convValue <= v;
    @(posedge clock);
    convStart <= 1'b0;
    if (peek)
    begin
      cmd(8'h02);
      rd(1'b0, 8'h80);
    end
    n = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end
    while (convDone !== 1'b1 && n < 30);
    check({7'h0, convDone}, 8'h01);
    @(posedge clock);
  endtask

  task automatic reset_scan();
    rst_b <= 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    pin(1'b1);
    foreach (rows[i])
    begin
      cmd(rows[i][15:8]);
      rd(1'b0, rows[i][7:0]);
    end
  endtask

  initial
  begin
    {rst_b, cmdStart, wrByte, wrSecond, rdByte, rdSecond} = '0;
    {convStart, remoteIn, openIn, pinFunctionSelect, alertRespond} = '0;
    {cmdPointer, wrData, convValue} = '0;
    err_count = 0;
    samples_checked = 0;
    reset_scan();
    foreach (lims[i])
    begin
      cmd(lims[i][31:24]);
      wr(lims[i][7:0], 1'b0);
      wr(8'h5c, 1'b1);
      cmd(lims[i][23:16]);
      rd(1'b0, lims[i][7:0]);
      rd(1'b1, 8'h50);
      cmd(lims[i][15:8]);
      wr(8'h6f, 1'b0);
      rd(1'b0, 8'h60);
    end
    cmd(8'h00);
    wr(8'hff, 1'b0);
    rd(1'b0, 8'h00);
    cmd(8'h20);
    wr(8'h30, 1'b0);
    cmd(8'h19);
    wr(8'h30, 1'b0);
    rd(1'b0, 8'h30);
    cmd(8'h21);
    wr(8'h05, 1'b0);
    rd(1'b0, 8'h05);
    conv(1'b0, 1'b0, 12'h35a, 1'b1);
    cmd(8'h00);
    rd(1'b0, 8'h35);
    conv(1'b0, 1'b0, 12'h368, 1'b0);
    cmd(8'h15);
    rd(1'b0, 8'ha0);
    cmd(8'h02);
    rd(1'b0, 8'h01);
    cmd(8'h15);
    rd(1'b0, 8'h80);
    cmd(8'h00);
    rd2(8'h36, 8'h80);
    conv(1'b0, 1'b0, 12'h2c0, 1'b0);
    cmd(8'h02);
    rd(1'b0, 8'h01);
    rd(1'b0, 8'h01);
    conv(1'b0, 1'b0, 12'h2b0, 1'b0);
    rd(1'b0, 8'h00);
    conv(1'b0, 1'b0, 12'h410, 1'b0);
    rd(1'b0, 8'h41);
    rd(1'b0, 8'h41);
    pin(1'b0);
    conv(1'b0, 1'b0, 12'h200, 1'b0);
    rd(1'b0, 8'h40);
    rd(1'b0, 8'h00);
    pin(1'b0);
    respond();
    pin(1'b1);
    conv(1'b1, 1'b1, 12'h7ff, 1'b0);
    rd(1'b0, 8'h04);
    rd(1'b0, 8'h04);
    conv(1'b1, 1'b0, 12'h05c, 1'b0);
    rd(1'b0, 8'h0c);
    rd(1'b0, 8'h08);
    pin(1'b0);
    respond();
    cmd(8'h01);
    rd2(8'h05, 8'hc0);
    pinFunctionSelect <= 1'b1;
    conv(1'b1, 1'b0, 12'h420, 1'b0);
    pin(1'b0);
    cmd(8'h02);
    rd(1'b0, 8'h1a);
    rd(1'b0, 8'h12);
    conv(1'b1, 1'b0, 12'h300, 1'b0);
    rd(1'b0, 8'h02);
    pin(1'b1);
    conv(1'b0, 1'b0, 12'h0f0, 1'b0);
    rd(1'b0, 8'h22);
    pinFunctionSelect <= 1'b0;
    reset_scan();
    stop_test();
  end

  initial
  begin
    #100000;
    err_count++;
    stop_test();
  end
endmodule
